// *** include/ebc_regs.svh ***
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH

// Register byte offsets
`define EBC_CTRL_OFS        12'h000
`define EBC_STAT_OFS        12'h004

// Control register fields
`define EBC_CTRL_WS_LSB     0
`define EBC_CTRL_CLOCK_OUT_DISABLE_BIT 4
`define EBC_CTRL_RST        32'h0000_0000

// Status register fields
`define EBC_STAT_STATE_LSB  0
`define EBC_STAT_HOLD_BIT   2
`define EBC_STAT_EMIF_BIT   3
`define EBC_STAT_BUSY_BIT   4

// Least software wait count at which ready is sampled
`define EBC_READY_MIN_WS    2

`endif

// *** include/ebc_pkg.sv ***
package ebc_pkg;

	typedef enum logic [1:0]
	{
		EBC_IDLE = 2'b00,
		EBC_ACC  = 2'b01,
		EBC_HOLD = 2'b10
	} ebc_state_e;

	typedef enum logic [1:0]
	{
		EBC_SP_PROG = 2'b00,
		EBC_SP_DATA = 2'b01,
		EBC_SP_IO   = 2'b10
	} ebc_space_e;

endpackage

// *** hw/ebc_machine_clock_out.sv ***
`timescale 1ns/1ps
`default_nettype none

module ebc_machine_clock_out
	import ebc_pkg::*;
#(
	parameter int HALF = 1
)
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic clock_out_disable,
	input  wire logic emu_float_n,
	// Pin
	output logic      mclk_out,
	output logic      mclk_oe_n,
	// Falling edge marks the start of a machine cycle
	output logic      mcycle_start
);

	logic [7:0] cnt_r;
	logic       clk_r;

	if (HALF < 1 || HALF > 255)
	begin : g_bad_half
		$error("ebc_machine_clock_out: HALF out of range");
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= 8'h00;
			clk_r <= 1'b1;
		end
		else if (clock_out_disable)
		begin
			// Parked high so restart begins with a clean falling edge
			cnt_r <= 8'h00;
			clk_r <= 1'b1;
		end
		else if (cnt_r == 8'(HALF - 1))
		begin
			cnt_r <= 8'h00;
			clk_r <= ~clk_r;
		end
		else
		begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign mclk_out     = clk_r;
	assign mclk_oe_n    = ~emu_float_n;
	assign mcycle_start = clk_r && !clock_out_disable && cnt_r == 8'(HALF - 1);

	a_clk_stops: assert property (@(posedge pclk) disable iff (!presetn)
		clock_out_disable ##1 clock_out_disable |=> $stable(mclk_out))
		else $error("clock output moved while disabled");
	a_clk_float: assert property (@(posedge pclk) disable iff (!presetn)
		!emu_float_n |-> mclk_oe_n)
		else $error("clock output driven while float low");
	a_clk_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(!clock_out_disable && cnt_r == 8'(HALF - 1))
		##1 !clock_out_disable |-> mclk_out != $past(mclk_out))
		else $error("clock output missed a toggle");

endmodule

`default_nettype wire

// *** hw/ebc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

module ebc_ctrl
	import ebc_pkg::*;
#(
	parameter int WS_W = 4,
	parameter int HALF = 1
)
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core access request
	input  wire logic        acc_req,
	input  wire logic        acc_write,
	input  wire logic [1:0]  acc_space,
	input  wire logic        acc_dma,
	input  wire logic        acc_addr18,
	output logic             acc_ready,
	output logic             acc_done,
	output logic             dma_io_local,
	// Mode and float pins
	input  wire logic        port_mode_select,
	input  wire logic        emu_float_n,
	// Ready pin (two-way)
	input  wire logic        ready_in,
	output logic             ready_out,
	output logic             ready_oe_n,
	input  wire logic        hp_data_ready,
	// Direction pin (two-way)
	input  wire logic        dir_in,
	output logic             dir_out,
	output logic             dir_oe_n,
	output logic             host_rw,
	// I/O strobe pin, shared with general pin 3
	input  wire logic        io_space_strobe_in,
	output logic             io_space_strobe_n,
	output logic             io_space_strobe_oe_n,
	input  wire logic        gp_pin_3_sub_a_out,
	input  wire logic        gp_pin_3_sub_a_oe_n,
	input  wire logic        timer_out_sub_a,
	input  wire logic        gp_sel_timer,
	output logic             gp_pin_3_sub_a_in,
	// Shared select / address bit 18 pin
	input  wire logic        sel_in,
	output logic             program_addr_bit_18,
	output logic             sel_oe_n,
	output logic             subsystem_select,
	// Hold
	input  wire logic        hold_req_n,
	output logic             bus_grant_out_n,
	output logic             grant_oe_n,
	output logic             bus_release,
	// Machine clock
	output logic             machine_clock_out,
	output logic             mclk_oe_n,
	output logic             mcycle_start
);

	localparam logic [WS_W-1:0] READY_MIN = WS_W'(`EBC_READY_MIN_WS);

	ebc_state_e      state_r;
	logic [WS_W-1:0] ws_cfg_r;
	logic [WS_W-1:0] ws_acc_r;
	logic [WS_W-1:0] wcnt_r;
	logic            clock_out_disable_r;
	logic            write_r;
	logic            io_space_strobe_r;
	logic            a18_r;
	logic            done_r;
	logic            dma_io_r;
	logic            emif;
	logic            hold_req;
	logic            start;
	logic            finish;
	logic            apb_wr;
	logic            apb_rd;

	// Count field must stay below the clock-off bit
	if (WS_W < 2 || WS_W > `EBC_CTRL_CLOCK_OUT_DISABLE_BIT)
	begin : g_bad_ws
		$error("ebc_ctrl: WS_W must be 2 to 4");
	end

	// Only CPU accesses reach the external I/O space
	function automatic logic cpu_io(input logic [1:0] sp, input logic dma);
		cpu_io = (sp == EBC_SP_IO) && !dma;
	endfunction

	function automatic logic dma_io(input logic [1:0] sp, input logic dma);
		dma_io = (sp == EBC_SP_IO) && dma;
	endfunction

	assign emif     = port_mode_select;
	assign hold_req = ~hold_req_n;

	// Hold wins ties in idle; accesses wait, never aborted
	assign acc_ready = emif && state_r == EBC_IDLE && !hold_req;
	assign start     = acc_req && acc_ready;
	// Ready ignored below the threshold; sampled low extends a cycle
	assign finish = state_r == EBC_ACC && wcnt_r == '0
		&& (ws_acc_r < READY_MIN || ready_in);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= EBC_IDLE;
		end
		else
		begin
			case (state_r)
				EBC_IDLE:
				begin
					if (start)
						state_r <= EBC_ACC;
					else if (hold_req && emif)
						state_r <= EBC_HOLD;
				end
				EBC_ACC:
				begin
					if (finish)
						state_r <= EBC_IDLE;
				end
				EBC_HOLD:
				begin
					if (!hold_req)
						state_r <= EBC_IDLE;
				end
				default:
				begin
					state_r <= EBC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ws_acc_r <= '0;
			wcnt_r   <= '0;
		end
		else if (start)
		begin
			ws_acc_r <= ws_cfg_r;
			wcnt_r   <= ws_cfg_r;
		end
		else if (state_r == EBC_ACC && wcnt_r != '0)
		begin
			wcnt_r <= wcnt_r - WS_W'(1);
		end
	end

	// Access-phase pin levels, held for the whole access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_r  <= 1'b0;
			io_space_strobe_r <= 1'b0;
			a18_r    <= 1'b0;
		end
		else if (start)
		begin
			write_r  <= acc_write && !dma_io(acc_space, acc_dma);
			io_space_strobe_r <= cpu_io(acc_space, acc_dma);
			a18_r    <= acc_addr18 && acc_space == EBC_SP_PROG;
		end
		else if (finish)
		begin
			write_r  <= 1'b0;
			io_space_strobe_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_r   <= 1'b0;
			dma_io_r <= 1'b0;
		end
		else
		begin
			done_r   <= finish;
			// DMA I/O served internally, no external strobe
			dma_io_r <= start && dma_io(acc_space, acc_dma);
		end
	end

	assign acc_done     = done_r;
	assign dma_io_local = dma_io_r;

	// Ready pin
	assign ready_out  = hp_data_ready;
	assign ready_oe_n = emif;

	// Direction pin; rests high between writes
	assign dir_out  = ~write_r;
	assign dir_oe_n = !emif || !emu_float_n || state_r == EBC_HOLD;
	assign host_rw  = emif ? 1'b1 : dir_in;

	// I/O strobe pin, reused as general pin 3 in host mode
	assign io_space_strobe_n = emif ? ~io_space_strobe_r
		: (gp_sel_timer ? timer_out_sub_a : gp_pin_3_sub_a_out);
	assign io_space_strobe_oe_n = !emu_float_n || state_r == EBC_HOLD
		|| (!emif && !gp_sel_timer && gp_pin_3_sub_a_oe_n);
	assign gp_pin_3_sub_a_in = io_space_strobe_in;

	// Shared select pin
	assign program_addr_bit_18 = a18_r;
	assign sel_oe_n = !emif || !emu_float_n || state_r == EBC_HOLD;
	assign subsystem_select = sel_in;

	// Hold handshake
	assign bus_release     = state_r == EBC_HOLD;
	assign bus_grant_out_n = state_r != EBC_HOLD;
	assign grant_oe_n      = !emu_float_n;

	ebc_machine_clock_out #(
		.HALF (HALF)
	) ebc_machine_clock_out_i (
		.pclk              (pclk),
		.presetn           (presetn),
		.clock_out_disable (clock_out_disable_r),
		.emu_float_n       (emu_float_n),
		.mclk_out          (machine_clock_out),
		.mclk_oe_n         (mclk_oe_n),
		.mcycle_start      (mcycle_start)
	);

	// APB slave: zero wait states
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable
		&& paddr != `EBC_CTRL_OFS && paddr != `EBC_STAT_OFS;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ws_cfg_r <= WS_W'(`EBC_CTRL_RST);
			clock_out_disable_r <= 1'b0;
		end
		else if (apb_wr && paddr == `EBC_CTRL_OFS)
		begin
			ws_cfg_r <= pwdata[`EBC_CTRL_WS_LSB +: WS_W];
			clock_out_disable_r <= pwdata[`EBC_CTRL_CLOCK_OUT_DISABLE_BIT];
		end
	end

	// Read data captured in setup, steady through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (apb_rd)
		begin
			prdata <= 32'h0000_0000;
			if (paddr == `EBC_CTRL_OFS)
			begin
				prdata[`EBC_CTRL_WS_LSB +: WS_W] <= ws_cfg_r;
				prdata[`EBC_CTRL_CLOCK_OUT_DISABLE_BIT]     <= clock_out_disable_r;
			end
			else if (paddr == `EBC_STAT_OFS)
			begin
				prdata[`EBC_STAT_STATE_LSB +: 2] <= state_r;
				prdata[`EBC_STAT_HOLD_BIT]       <= hold_req;
				prdata[`EBC_STAT_EMIF_BIT]       <= emif;
				prdata[`EBC_STAT_BUSY_BIT]       <= state_r == EBC_ACC;
			end
		end
	end

	a_ready_extends: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == EBC_ACC && wcnt_r == '0 && ws_acc_r >= READY_MIN
		&& !ready_in |=> state_r == EBC_ACC && !acc_done)
		else $error("access ended with ready low");
	a_ready_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == EBC_ACC && wcnt_r == '0 && ws_acc_r < READY_MIN
		|=> state_r != EBC_ACC ##0 acc_done)
		else $error("ready not ignored below two waits");
	a_wait_length: assert property (@(posedge pclk) disable iff (!presetn)
		start && ws_cfg_r == WS_W'(1) |=> state_r == EBC_ACC ##1
		state_r == EBC_ACC ##1 state_r == EBC_IDLE)
		else $error("one wait state mistimed");
	a_dir_rest: assert property (@(posedge pclk) disable iff (!presetn)
		!dir_out |-> state_r == EBC_ACC)
		else $error("direction low outside write");
	a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
		start && acc_write && !acc_dma |=> !dir_out)
		else $error("write did not drive direction low");
	a_io_space_strobe_dma: assert property (@(posedge pclk) disable iff (!presetn)
		start && acc_dma |=> !io_space_strobe_r
		&& dma_io_local == ($past(acc_space) == EBC_SP_IO))
		else $error("dma access raised the strobe");
	a_io_space_strobe_cpu: assert property (@(posedge pclk) disable iff (!presetn)
		start && cpu_io(acc_space, acc_dma) |=> !io_space_strobe_n)
		else $error("cpu I/O access without strobe");
	a_hold_after_acc: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == EBC_ACC && !finish |=> state_r != EBC_HOLD)
		else $error("hold granted mid-access");
	a_hold_grant: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == EBC_IDLE && hold_req && emif && !acc_req
		|=> !bus_grant_out_n && bus_release && dir_oe_n && io_space_strobe_oe_n)
		else $error("hold not granted with lines floated");
	a_float_all: assert property (@(posedge pclk) disable iff (!presetn)
		!emu_float_n |-> dir_oe_n && io_space_strobe_oe_n && grant_oe_n && sel_oe_n)
		else $error("output driven while float low");
	a_host_pins: assert property (@(posedge pclk) disable iff (!presetn)
		!emif |-> !ready_oe_n && dir_oe_n && sel_oe_n && !acc_ready)
		else $error("host mode pin directions wrong");
	a_emif_ready_in: assert property (@(posedge pclk) disable iff (!presetn)
		emif |-> ready_oe_n)
		else $error("ready pin driven in memory mode");

endmodule

`default_nettype wire

// *** tb/ebc_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module ebc_mem
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Access start and stall length
	input  wire logic       start,
	input  wire logic [3:0] low,
	// Ready pin
	output logic            ready_in
);
	logic [3:0] cnt_r;

	// Counts edges from the take, so stall length is exact
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= 4'h0;
		else if (start)
			cnt_r <= low;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end

	assign ready_in = (cnt_r == 4'h0);
endmodule

`default_nettype wire

// *** tb/ebc_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

module ebc_ctrl_tb
	import ebc_pkg::*;
;
	typedef struct {int lat; logic dir, strb, a18, p, dl;} ebc_note_s;
	ebc_note_s   q[$];
	ebc_note_s   n;
	logic        pclk, presetn, psel, penable, pwrite, acc_req, acc_write;
	logic        acc_dma, acc_addr18, port_mode_select, emu_float_n;
	logic        hp_data_ready, gp_pin_3_sub_a_out, gp_pin_3_sub_a_oe_n;
	logic        timer_out_sub_a, gp_sel_timer, hold_req_n, h_dir, h_sel;
	logic        h_io, st_go, er, m, ms, xs, xo;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  acc_space;
	logic [3:0]  st_len;
	logic        pready, pslverr, acc_ready, acc_done, dma_io_local;
	logic        ready_out, ready_oe_n, dir_out, dir_oe_n, host_rw;
	logic        io_space_strobe_n, io_space_strobe_oe_n, gp_pin_3_sub_a_in;
	logic        program_addr_bit_18, sel_oe_n, subsystem_select;
	logic        bus_grant_out_n, grant_oe_n, bus_release;
	logic        machine_clock_out, mclk_oe_n, mcycle_start;
	wire         ready_in, dir_in, io_space_strobe_in, sel_in, mem_rdy;
	int          error_cnt, comparisons, lat, k, f;

	// Pin levels resolved from the controller's output enables
	assign ready_in = ready_oe_n ? mem_rdy : ready_out;
	assign dir_in = dir_oe_n ? h_dir : dir_out;
	assign io_space_strobe_in = io_space_strobe_oe_n ? h_io : io_space_strobe_n;
	assign sel_in = sel_oe_n ? h_sel : program_addr_bit_18;

	ebc_ctrl ebc_ctrl_i
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .acc_req, .acc_write, .acc_space,
		.acc_dma, .acc_addr18, .acc_ready, .acc_done, .dma_io_local,
		.port_mode_select, .emu_float_n, .ready_in, .ready_out,
		.ready_oe_n, .hp_data_ready, .dir_in, .dir_out, .dir_oe_n,
		.host_rw, .io_space_strobe_in, .io_space_strobe_n, .io_space_strobe_oe_n,
		.gp_pin_3_sub_a_out, .gp_pin_3_sub_a_oe_n, .timer_out_sub_a,
		.gp_sel_timer, .gp_pin_3_sub_a_in, .sel_in, .program_addr_bit_18,
		.sel_oe_n, .subsystem_select, .hold_req_n, .bus_grant_out_n,
		.grant_oe_n, .bus_release, .machine_clock_out, .mclk_oe_n,
		.mcycle_start
	);

	ebc_mem ebc_mem_i
	(
		.pclk, .presetn, .start(st_go), .low(st_len), .ready_in(mem_rdy)
	);

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic timeout_hit;
		error_cnt++;
		$display("Wait limit ran out at %0t", $time);
		report_and_stop;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			timeout_hit;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic drain;
		int j;
		for (j = 0; j < 40 && q.size() != 0; j++)
			@(posedge pclk);
		if (j == 40)
			timeout_hit;
	endtask

	// Ready stall only extends the access once the wait count has run out
	task automatic run(input int w, input logic [3:0] l, input logic wr,
		input ebc_space_e sp, input logic dma, input logic hq);
		logic a;
		int e;
		apb(1'b1, `EBC_CTRL_OFS, 32'(w));
		a = 1'($urandom);
		e = (w >= `EBC_READY_MIN_WS && l > w) ? l + 2 : w + 2;
		acc_req <= 1'b1;
		acc_write <= wr;
		acc_space <= sp;
		acc_dma <= dma;
		acc_addr18 <= a;
		st_go <= 1'b1;
		st_len <= l;
		q.push_back('{e, ~wr, !(sp == EBC_SP_IO && !dma), a,
			sp == EBC_SP_PROG, sp == EBC_SP_IO && dma});
		@(posedge pclk);
		acc_req <= 1'b0;
		st_go <= 1'b0;
		hold_req_n <= !hq;
		drain;
	endtask

	task automatic count_falls;
		f = 0;
		@(posedge pclk);
		m = machine_clock_out;
		ms = mcycle_start;
		repeat (8)
		begin
			@(posedge pclk);
			// A fall counts only when the cycle before flagged it
			if (m && !machine_clock_out && ms)
				f++;
			m = machine_clock_out;
			ms = mcycle_start;
		end
	endtask

	always @(posedge pclk)
	begin
		if (acc_req === 1'b1 && acc_ready === 1'b1)
			lat = 0;
		else
			lat++;
		if (lat >= 1 && q.size() > 0)
			check(32'(bus_grant_out_n), 32'h1);
		if (lat == 1 && q.size() > 0)
		begin
			check(32'(dir_out), 32'(q[0].dir));
			check(32'(io_space_strobe_n), 32'(q[0].strb));
			check(32'(dma_io_local), 32'(q[0].dl));
			if (q[0].p)
				check(32'(program_addr_bit_18), 32'(q[0].a18));
		end
		if (acc_done === 1'b1 && q.size() > 0)
		begin
			n = q.pop_front();
			check(32'(lat), 32'(n.lat));
		end
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		timeout_hit;
	end

	initial
	begin
		{psel, penable, pwrite, acc_req, acc_write, acc_dma} = '0;
		{acc_addr18, st_go, hp_data_ready, gp_pin_3_sub_a_out} = '0;
		{gp_pin_3_sub_a_oe_n, timer_out_sub_a, gp_sel_timer} = '0;
		{h_dir, h_sel, h_io} = '0;
		{port_mode_select, emu_float_n, hold_req_n} = 3'b111;
		{paddr, pwdata, acc_space, st_len} = '0;
		error_cnt = 0;
		comparisons = 0;
		lat = 100;
		presetn = 1'b0;
		k = $urandom(87428);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `EBC_CTRL_OFS, 32'h0);
		check(rd, `EBC_CTRL_RST);
		apb(1'b0, 12'h010, 32'h0);
		check(32'(er), 32'h1);
		check(rd, 32'h0);
		$display("end of register test");
		run(0, 4'ha, 1'b1, EBC_SP_IO, 1'b0, 1'b0);
		run(1, 4'ha, 1'b0, EBC_SP_DATA, 1'b0, 1'b0);
		run(2, 4'h0, 1'b1, EBC_SP_PROG, 1'b0, 1'b0);
		run(2, 4'h6, 1'b0, EBC_SP_IO, 1'b1, 1'b0);
		run(3, 4'ha, 1'b1, EBC_SP_IO, 1'b0, 1'b0);
		run(5, 4'h3, 1'b0, EBC_SP_PROG, 1'b0, 1'b0);
		$display("end of access test");
		run(3, 4'h2, 1'b1, EBC_SP_DATA, 1'b0, 1'b1);
		for (k = 0; k < 10 && bus_grant_out_n !== 1'b0; k++)
			@(posedge pclk);
		check(32'(bus_grant_out_n), 32'h0);
		check(32'({bus_release, dir_oe_n, sel_oe_n}), 32'h7);
		check(32'(acc_ready), 32'h0);
		hold_req_n <= 1'b1;
		repeat (2) @(posedge pclk);
		check(32'(bus_grant_out_n), 32'h1);
		$display("end of hold test");
		emu_float_n <= 1'b0;
		repeat (2) @(posedge pclk);
		check(32'({dir_oe_n, io_space_strobe_oe_n, grant_oe_n}), 32'h7);
		check(32'(mclk_oe_n), 32'h1);
		emu_float_n <= 1'b1;
		repeat (2) @(posedge pclk);
		check(32'({dir_oe_n, grant_oe_n, mclk_oe_n}), 32'h0);
		apb(1'b1, `EBC_CTRL_OFS, 32'h1 << `EBC_CTRL_CLOCK_OUT_DISABLE_BIT);
		count_falls;
		check(32'(f), 32'h0);
		apb(1'b1, `EBC_CTRL_OFS, 32'h0);
		count_falls;
		check(32'(f), 32'h4);
		$display("end of float and clock test");
		port_mode_select <= 1'b0;
		repeat (4)
		begin
			{hp_data_ready, h_dir, h_sel, timer_out_sub_a} <= 4'($urandom);
			{gp_pin_3_sub_a_out, gp_sel_timer, h_io,
				gp_pin_3_sub_a_oe_n} <= 4'($urandom);
			@(posedge pclk);
			xs = gp_sel_timer ? timer_out_sub_a : gp_pin_3_sub_a_out;
			xo = !gp_sel_timer && gp_pin_3_sub_a_oe_n;
			check(32'({ready_oe_n, ready_out}),
				32'(hp_data_ready));
			check(32'({dir_oe_n, host_rw}), 32'({1'b1, h_dir}));
			check(32'(io_space_strobe_n), 32'(xs));
			check(32'({io_space_strobe_oe_n, gp_pin_3_sub_a_in}),
				32'({xo, (xo ? h_io : xs)}));
			check(32'({sel_oe_n, subsystem_select}),
				32'({1'b1, h_sel}));
			check(32'(acc_ready), 32'h0);
		end
		port_mode_select <= 1'b1;
		repeat (2) @(posedge pclk);
		check(32'({sel_oe_n, host_rw, ready_oe_n}), 32'h3);
		$display("end of port mode test");
		report_and_stop;
	end
endmodule

`default_nettype wire
